// ### srwg_consts.svh
// Constants of the special register write guard: offsets, fields, resets, timing.
// Assumes a 32-bit APB register bus with word-aligned byte addresses.
`ifndef SRWG_CONSTS_SVH
`define SRWG_CONSTS_SVH

// Register byte offsets
`define SRWG_OFF_PROTECT_CMD   8'h00
`define SRWG_OFF_SYS_STATUS    8'h04
`define SRWG_OFF_POWER_SAVE    8'h08
`define SRWG_OFF_PERIPH_WAIT   8'h0C
`define SRWG_OFF_DEBUG_MODE    8'h10
`define SRWG_OFF_WATCHDOG_MODE 8'h14
`define SRWG_OFF_INT_STATUS    8'h18
`define SRWG_OFF_INT_MASK      8'h1C

// Field positions
`define SRWG_BIT_PROT_ERR      0
`define SRWG_BIT_STOP_REQ      1
`define SRWG_BIT_DEBUG_EN      0
`define SRWG_EV_ERROR          0
`define SRWG_EV_UNLOCK         1
`define SRWG_EV_REJECT         2

// Field widths
`define SRWG_WAIT_W            2
`define SRWG_WDT_W             8
`define SRWG_EV_W              3

// Reset values
`define SRWG_RST_WAIT          2'h0
`define SRWG_RST_WDT           8'h00
`define SRWG_RST_DEBUG         1'h1
`define SRWG_RST_MASK          3'h0

// Peripheral register access length without wait cycles, in clocks
`define SRWG_BASE_ACCESS       3

`endif

// ### srwg_cpu_model.sv
// CPU core model issuing stores and loads on the guard's APB port.
// Assumes it shares sys_clk with the guard; the bench calls its tasks.
`timescale 1ns/1ps
`include "srwg_consts.svh"
module srwg_cpu_model (
	input  wire logic        sys_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	int          cycles;  // Clocks of last access, setup edge to pready edge
	logic        lastErr; // Error response of last access
	logic [31:0] rdata;   // Data of last read
	// Bus idle at time zero
	initial begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end
	// One transfer, request held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		cycles = 1;
		@(posedge sys_clk);
		penable <= 1'h1;
		// Wait for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge sys_clk);
			cycles++;
		end while (pready !== 1'h1);
		rdata   = prdata;
		lastErr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	// Command store then special store, same data, nothing between
	task automatic unlock(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, `SRWG_OFF_PROTECT_CMD, d);
		xfer(1'h1, a, d);
	endtask
endmodule

// ### srwg_guard.sv
// APB register bank guarding special registers behind a protect command write.
// Assumes an APB master on sys_clk and a synchronous active-high srst.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "srwg_consts.svh"

module srwg_guard
	import srwg_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    srst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic                         irq,
	output logic                         intHold,
	output logic                         stopRequest,
	output logic                         debugMode,
	output logic      [`SRWG_WAIT_W-1:0] waitCycles,
	output logic      [`SRWG_WDT_W-1:0]  watchdogMode
);

	// Address match against one register offset
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	srwg_phase_e                 phase;        // Slave transfer phase
	srwg_phase_e                 next_phase;   // Next transfer phase
	logic [`SRWG_WAIT_W-1:0]     waitCnt;      // Wait cycles spent
	logic                        armed;        // Last write hit command reg while unarmed
	logic                        protErr;      // Protection error flag
	logic [`SRWG_EV_W-1:0]       intStat;      // Sticky event bits
	logic [`SRWG_EV_W-1:0]       intMask;      // Event enables
	logic [`SRWG_EV_W-1:0]       next_intStat; // Next event bits
	logic                        next_armed;   // Next unlock state

	// Decoding of the completing transfer
	wire accDone  = psel & penable & pready;
	wire wrDone   = accDone & pwrite;
	wire rdDone   = accDone & ~pwrite;
	wire selCmd   = hit(paddr, `SRWG_OFF_PROTECT_CMD);
	wire selSys   = hit(paddr, `SRWG_OFF_SYS_STATUS);
	wire selPwr   = hit(paddr, `SRWG_OFF_POWER_SAVE);
	wire selWait  = hit(paddr, `SRWG_OFF_PERIPH_WAIT);
	wire selDbg   = hit(paddr, `SRWG_OFF_DEBUG_MODE);
	wire selWdt   = hit(paddr, `SRWG_OFF_WATCHDOG_MODE);
	wire selIst   = hit(paddr, `SRWG_OFF_INT_STATUS);
	wire selImk   = hit(paddr, `SRWG_OFF_INT_MASK);
	wire selAny   = selCmd | selSys | selPwr | selWait | selDbg | selWdt | selIst | selImk;
	wire selSpec  = selPwr | selDbg;
	wire wrCmd    = wrDone & selCmd;
	wire wrSys    = wrDone & selSys;
	wire specOk   = wrDone & selSpec & armed;
	wire specBad  = wrDone & selSpec & ~armed;
	wire cmdAgain = wrCmd & armed;
	wire errSet   = cmdAgain | specBad;
	wire errClr   = wrSys & ~pwdata[`SRWG_BIT_PROT_ERR];
	wire evErr    = errSet;
	wire evUnlock = specOk;
	wire evReject = specBad;
	wire waitDone = (waitCnt == waitCycles);

	// Read data selection
	wire [31:0] rdMux =
		selSys  ? {31'h0, protErr} :
		selPwr  ? {30'h0, stopRequest, 1'h0} :
		selWait ? {30'h0, waitCycles} :
		selDbg  ? {31'h0, debugMode} :
		selWdt  ? {24'h0, watchdogMode} :
		selIst  ? {29'h0, intStat} :
		selImk  ? {29'h0, intMask} : 32'h0;

	// Transfer phase sequencing; pready rises after base access plus waits
	always_comb begin
		next_phase = phase;
		case (phase)
			PH_IDLE: begin
				if (psel & ~penable) begin
					next_phase = PH_WAIT;
				end
			end
			PH_WAIT: begin
				if (psel & penable & waitDone) begin
					next_phase = PH_DONE;
				end
			end
			PH_DONE: begin
				next_phase = PH_IDLE;
			end
			default: begin
				next_phase = PH_IDLE;
			end
		endcase
	end

	// Unlock is armed by a command write while unarmed and spent by any other write or a repeated command write
	always_comb begin
		next_armed = armed;
		if (wrDone) begin
			next_armed = wrCmd & ~armed;
		end
	end

	// Event bits: new events win over the read that clears them
	always_comb begin
		next_intStat = intStat;
		if (rdDone & selIst) begin
			next_intStat = '0;
		end
		next_intStat[`SRWG_EV_ERROR]  = next_intStat[`SRWG_EV_ERROR] | evErr;
		next_intStat[`SRWG_EV_UNLOCK] = next_intStat[`SRWG_EV_UNLOCK] | evUnlock;
		next_intStat[`SRWG_EV_REJECT] = next_intStat[`SRWG_EV_REJECT] | evReject;
	end

	// Bus phase and wait counter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase   <= PH_IDLE;
			waitCnt <= '0;
		end else begin
			phase   <= next_phase;
			waitCnt <= (phase == PH_WAIT && !waitDone) ? waitCnt + 1'b1 : '0;
		end
	end

	// Bus answer registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= (next_phase == PH_DONE);
			pslverr <= (next_phase == PH_DONE) & ~selAny;
			prdata  <= (next_phase == PH_DONE && !pwrite) ? rdMux : 32'h0;
		end
	end

	// Unlock state, error flag, interrupt hold
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			armed   <= 1'b0;
			protErr <= 1'b0;
			intHold <= 1'b0;
		end else begin
			armed   <= next_armed;
			intHold <= next_armed;
			if (errClr) begin
				protErr <= 1'b0;
			end else if (errSet) begin
				protErr <= 1'b1;
			end
		end
	end

	// Special registers change only on an accepted unlock
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stopRequest <= 1'b0;
			debugMode   <= `SRWG_RST_DEBUG;
		end else begin
			if (specOk & selPwr) begin
				stopRequest <= pwdata[`SRWG_BIT_STOP_REQ];
			end
			if (specOk & selDbg) begin
				debugMode <= pwdata[`SRWG_BIT_DEBUG_EN];
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			waitCycles   <= `SRWG_RST_WAIT;
			watchdogMode <= `SRWG_RST_WDT;
			intMask      <= `SRWG_RST_MASK;
		end else begin
			if (wrDone & selWait) begin
				waitCycles <= pwdata[`SRWG_WAIT_W-1:0];
			end
			if (wrDone & selWdt) begin
				watchdogMode <= pwdata[`SRWG_WDT_W-1:0];
			end
			if (wrDone & selImk) begin
				intMask <= pwdata[`SRWG_EV_W-1:0];
			end
		end
	end

	// Interrupt status and level output, silenced while unlock armed
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			intStat <= '0;
			irq     <= 1'b0;
		end else begin
			intStat <= next_intStat;
			irq     <= (|(next_intStat & intMask)) & ~next_armed;
		end
	end

	// Helper: clocks since the setup cycle of the current transfer
	logic [3:0] accLen; // Clock count of the running transfer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			accLen <= 4'h0;
		end else if (psel & ~penable) begin
			accLen <= 4'h1;
		end else if (psel & penable & ~pready) begin
			accLen <= accLen + 4'h1;
		end
	end

	// Transfer with zero waits completes on its third clock
	property p_base_access;
		@(posedge sys_clk) disable iff (srst)
		(accDone && waitCycles == '0) |-> (accLen == 4'h2);
	endproperty
	a_base_access: assert property (p_base_access) else $error("access length wrong");

	// Each wait cycle adds one clock
	property p_wait_access;
		@(posedge sys_clk) disable iff (srst)
		accDone |-> (accLen == 4'h2 + {2'h0, waitCycles});
	endproperty
	a_wait_access: assert property (p_wait_access) else $error("wait count ignored");

	// Repeated command write sets the error flag
	property p_cmd_again;
		@(posedge sys_clk) disable iff (srst)
		(wrCmd && armed) |=> protErr;
	endproperty
	a_cmd_again: assert property (p_cmd_again) else $error("repeat command no error");

	// Zero write to status right after command clears the flag
	property p_clear_wins;
		@(posedge sys_clk) disable iff (srst)
		(wrSys && armed && !pwdata[`SRWG_BIT_PROT_ERR]) |=> !protErr;
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("error not cleared");

	// Unarmed special write is discarded and flagged
	property p_reject;
		@(posedge sys_clk) disable iff (srst)
		(wrDone && selPwr && !armed) |=> (protErr && $stable(stopRequest));
	endproperty
	a_reject: assert property (p_reject) else $error("unarmed write accepted");

	// Armed special write lands and clears arming
	property p_accept;
		@(posedge sys_clk) disable iff (srst)
		(wrDone && selDbg && armed) |=> (debugMode == $past(pwdata[0]) && !armed);
	endproperty
	a_accept: assert property (p_accept) else $error("armed write lost");

	// No interrupt while the unlock is armed
	property p_hold;
		@(posedge sys_clk) disable iff (srst)
		armed |-> (!irq && intHold);
	endproperty
	a_hold: assert property (p_hold) else $error("interrupt during unlock");

	// Scenarios worth seeing
	property p_cv_unlock;
		@(posedge sys_clk) disable iff (srst)
		wrCmd ##[1:20] specOk;
	endproperty
	c_cv_unlock: cover property (p_cv_unlock);

	property p_cv_double;
		@(posedge sys_clk) disable iff (srst)
		cmdAgain;
	endproperty
	c_cv_double: cover property (p_cv_double);

	property p_cv_waits;
		@(posedge sys_clk) disable iff (srst)
		accDone && waitCycles == 2'h3;
	endproperty
	c_cv_waits: cover property (p_cv_waits);

	// A refused special write leaves its mark in the event bits
	property p_reject_event;
		@(posedge sys_clk) disable iff (srst)
		specBad |=> intStat[`SRWG_EV_REJECT];
	endproperty
	a_reject_event: assert property (p_reject_event) else $error("reject event lost");

	property p_cv_reject;
		@(posedge sys_clk) disable iff (srst)
		specBad;
	endproperty
	c_cv_reject: cover property (p_cv_reject);

endmodule

// ### srwg_pkg.sv
// Types shared by the special register write guard.
// Assumes srwg_consts.svh supplies the numeric constants.
package srwg_pkg;
	// Phase of the APB slave handling one transfer
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WAIT,
		PH_DONE
	} srwg_phase_e;

	// One bus data word
	typedef logic [31:0] srwg_word_t;
endpackage

// ### test_special_register_write_guard.sv
// Self-checking bench for the write guard, CPU model as bus master.
// Assumes srwg_pkg and srwg_consts.svh are compiled with the guard.
`timescale 1ns/1ps
`include "srwg_consts.svh"
module test_special_register_write_guard
	import srwg_pkg::*;
;
	logic        sysClk = 1'h0;                   // 125 MHz clock
	logic        srst   = 1'h1;                   // Reset held at start
	logic        psel, penable, pwrite, pready;   // Bus handshake
	logic        pslverr, irq, intHold;           // Status outputs
	logic        stopRequest, debugMode;          // Control outputs
	logic [1:0]  waitCycles;                      // Wait setting
	logic [7:0]  paddr, watchdogMode;             // Address, watchdog setting
	logic [31:0] pwdata, prdata;                  // Bus data
	int          mismatches = 0;                  // Failed compares
	int          compares   = 0;                  // All compares
	// Clock, 8 ns period
	always #4 sysClk = ~sysClk;
	srwg_guard dut (.sys_clk(sysClk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .intHold(intHold), .stopRequest(stopRequest),
		.debugMode(debugMode), .waitCycles(waitCycles), .watchdogMode(watchdogMode));
	srwg_cpu_model cpu (.sys_clk(sysClk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	// Bus shorthands
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu.xfer(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		cpu.xfer(1'h0, a, 32'h0);
	endtask
	// Let n edges pass, then sample settled outputs
	task automatic step(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask
	task automatic chk(input srwg_word_t got, input srwg_word_t exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	// Test sequence
	initial begin
		repeat (8) @(posedge sysClk);
		srst <= 1'h0;
		step(1);
		chk(debugMode, 1'h1);
		chk(waitCycles, 2'h0);
		chk(watchdogMode, 8'h00);
		wr(`SRWG_OFF_PERIPH_WAIT, 32'h0);
		chk(cpu.cycles, 3);
		$display("test reset done");
		// Special write without command is refused
		wr(`SRWG_OFF_INT_MASK, 32'h4);
		wr(`SRWG_OFF_DEBUG_MODE, 32'h0);
		step(2);
		chk(debugMode, 1'h1);
		chk(irq, 1'h1);
		rd(`SRWG_OFF_SYS_STATUS);
		chk(cpu.rdata, 32'h1);
		rd(`SRWG_OFF_INT_STATUS);
		chk(cpu.rdata & 32'h4, 32'h4);
		step(2);
		chk(irq, 1'h0);
		$display("test reject done");
		// Error clear after command, then double command
		cpu.unlock(`SRWG_OFF_SYS_STATUS, 32'h0);
		rd(`SRWG_OFF_SYS_STATUS);
		chk(cpu.rdata, 32'h0);
		wr(`SRWG_OFF_PROTECT_CMD, 32'h0);
		wr(`SRWG_OFF_PROTECT_CMD, 32'h0);
		rd(`SRWG_OFF_SYS_STATUS);
		chk(cpu.rdata, 32'h1);
		$display("test error flag done");
		// Interrupt held off while armed, special write accepted
		wr(`SRWG_OFF_DEBUG_MODE, 32'h0);
		wr(`SRWG_OFF_PROTECT_CMD, 32'h0);
		step(2);
		chk(intHold, 1'h1);
		chk(irq, 1'h0);
		wr(`SRWG_OFF_DEBUG_MODE, 32'h0);
		step(2);
		chk(debugMode, 1'h0);
		chk(intHold, 1'h0);
		chk(irq, 1'h1);
		rd(`SRWG_OFF_INT_STATUS);
		chk(cpu.rdata, 32'h7);
		$display("test unlock done");
		// Stop request, five idle cycles follow
		cpu.unlock(`SRWG_OFF_POWER_SAVE, 32'h2);
		step(5);
		chk(stopRequest, 1'h1);
		// Longest wait setting, plain registers, unmapped place
		wr(`SRWG_OFF_PERIPH_WAIT, 32'h3);
		wr(`SRWG_OFF_WATCHDOG_MODE, 32'hA5);
		step(2);
		chk(waitCycles, 2'h3);
		chk(watchdogMode, 8'hA5);
		rd(`SRWG_OFF_WATCHDOG_MODE);
		chk(cpu.cycles, 6);
		chk(cpu.rdata, 32'hA5);
		rd(8'h20);
		chk(cpu.lastErr, 1'h1);
		chk(cpu.rdata, 32'h0);
		$display("test timing done");
		tally_and_finish();
	end
endmodule
